//--- slb_host_model.sv
// slb_host_model.sv: host processor model driving the register port
`timescale 1ns/10ps
module slb_host_model (
   // clock
   input wire logic sys_clk_i,
   // register port
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i,
   // external sysref
   output logic sysref_o
);
   // ****************************************
   // host accesses
   // ****************************************
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      sysref_o = 1'b0;
   end
   // released bus shows inverted value, never a stale copy
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= d;
      @(posedge sys_clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask
   task automatic commit();
      wr(slb_pkg::REG_COMMIT, slb_pkg::COMMIT_CODE);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(posedge sys_clk_i);
      reg_rd_o <= 1'b1;
      reg_addr_o <= a;
      @(posedge sys_clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      // answer taken at the edge that samples it; it drops right after
      @(posedge sys_clk_i);
      v = reg_rvalid_i;
      d = reg_rdata_i;
   endtask
   task automatic pulse(input int n);
      @(posedge sys_clk_i);
      sysref_o <= 1'b1;
      repeat (n) @(posedge sys_clk_i);
      sysref_o <= 1'b0;
   endtask
endmodule

//--- slb_pkg.sv
// slb_pkg.sv: register map, codes and timing constants of the bring-up sequencer
package slb_pkg;
   // ********************************************************
   // register offsets
   // ********************************************************
   localparam logic [7:0] REG_LOCK_STATUS = 8'h0a;
   localparam logic [7:0] REG_SYSREF_CTRL = 8'h3a;
   localparam logic [7:0] REG_PHY_CTRL = 8'h5f;
   localparam logic [7:0] REG_DLY_FIRST = 8'hee;
   localparam logic [7:0] REG_DLY_SECOND = 8'hef;
   localparam logic [7:0] REG_FIFO_ALIGN = 8'hf3;
   localparam logic [7:0] REG_COMMIT = 8'hff;
   // ********************************************************
   // codes and reset values
   // ********************************************************
   localparam logic [7:0] COMMIT_CODE = 8'h01;
   localparam logic [7:0] LOCK_CODE = 8'h81;
   localparam logic [7:0] UNLOCK_CODE = 8'h00;
   localparam logic [7:0] SYSREF_BUF_ONLY = 8'h01;
   localparam logic [7:0] SYSREF_ONE_SHOT = 8'h0f;
   localparam logic [7:0] SYSREF_PERIODIC = 8'h03;
   localparam logic [7:0] SYSREF_BUF_OFF = 8'h04;
   localparam logic [7:0] SYSREF_RST = 8'h00;
   localparam logic [7:0] PHY_ENABLE = 8'h14;
   localparam logic [7:0] PHY_DISABLE = 8'h15;
   localparam logic [7:0] PHY_RST = 8'h15;
   localparam logic [7:0] ALIGN_CODE = 8'hff;
   localparam logic [7:0] DLY_RST = 8'h80;
   localparam int unsigned DLY_FIELD_LSB = 0;
   localparam int unsigned DLY_FIELD_W = 3;
   // ********************************************************
   // timing
   // ********************************************************
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned CGS_TIME_NS = 400;
   localparam int unsigned CGS_CYCLES =
      (CGS_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   typedef enum logic [1:0] {SLB_LINK_IDLE, SLB_LINK_CGS, SLB_LINK_UP}
      slb_link_t;
endpackage

//--- slb_sequencer.sv
// slb_sequencer.sv: register file and link bring-up logic of the device
`timescale 1ns/10ps
// Notes on behaviour
// - committed sysref 0x0f selects one-shot, 0x03 selects periodic
// - commit writing 0x01 applies staged local register values
// - lock status reads 0x81 while the link pll is locked
// - phy control 0x14 enables phy and starts code group sync one cycle later
// - writing 0xff to fifo align register forces an internal fifo alignment
// - delay register writes tune fifo write and read clock delays
// - phy control 0x15 disables the phy, link stays idle
module slb_sequencer (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // link side
   input wire logic pll_locked_i,
   input wire logic sysref_i,
   output logic phy_en_o,
   output logic cgs_active_o,
   output logic link_up_o,
   output logic fifo_align_o,
   output logic sysref_buf_en_o,
   output logic sysref_one_shot_o,
   output logic sysref_periodic_o,
   output logic sysref_capture_o,
   output logic [2:0] fifo_wr_dly_o,
   output logic [2:0] fifo_rd_dly_o
);
   // ********************************************************
   // staged and live registers
   // ********************************************************
   logic [7:0] sysref_stage_q;
   logic [7:0] sysref_live_q;
   logic [7:0] phy_q;
   logic [7:0] dly1_q;
   logic [7:0] dly2_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic align_q;
   logic one_shot_done_q;
   logic [15:0] cgs_cnt_q;
   slb_pkg::slb_link_t link_q;

   function automatic logic hit(input logic [7:0] a);
      hit = reg_wr_i && (reg_addr_i == a);
   endfunction

   logic commit;
   assign commit = hit(slb_pkg::REG_COMMIT) &&
      (reg_wdata_i == slb_pkg::COMMIT_CODE);

   // local register staged, made live by the transfer command
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         sysref_stage_q <= slb_pkg::SYSREF_RST;
         sysref_live_q <= slb_pkg::SYSREF_RST;
      end else begin
         if (hit(slb_pkg::REG_SYSREF_CTRL)) begin
            sysref_stage_q <= reg_wdata_i;
         end
         if (commit) begin
            sysref_live_q <= sysref_stage_q;
         end
      end
   end

   // ********************************************************
   // sysref handling
   // ********************************************************
   // buffer bit 0 on in 0x01, 0x03 and 0x0f; off in 0x04
   assign sysref_buf_en_o = sysref_live_q[0];
   assign sysref_one_shot_o =
      (sysref_live_q == slb_pkg::SYSREF_ONE_SHOT);
   assign sysref_periodic_o =
      (sysref_live_q == slb_pkg::SYSREF_PERIODIC);

   // one-shot arms once; buffer-only mode never triggers, so no false hit
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         one_shot_done_q <= 1'b0;
         sysref_capture_o <= 1'b0;
      end else begin
         sysref_capture_o <= 1'b0;
         if (!sysref_one_shot_o) begin
            one_shot_done_q <= 1'b0;
         end
         if (sysref_i && sysref_periodic_o) begin
            sysref_capture_o <= 1'b1;
         end
         if (sysref_i && sysref_one_shot_o && !one_shot_done_q) begin
            sysref_capture_o <= 1'b1;
            one_shot_done_q <= 1'b1;
         end
      end
   end

   // ********************************************************
   // phy and link establishment
   // ********************************************************
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         phy_q <= slb_pkg::PHY_RST;
      end else if (hit(slb_pkg::REG_PHY_CTRL)) begin
         phy_q <= reg_wdata_i;
      end
   end
   assign phy_en_o = (phy_q == slb_pkg::PHY_ENABLE);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         link_q <= slb_pkg::SLB_LINK_IDLE;
         cgs_cnt_q <= '0;
      end else begin
         case (link_q)
            slb_pkg::SLB_LINK_IDLE: begin
               cgs_cnt_q <= '0;
               if (phy_en_o) begin
                  link_q <= slb_pkg::SLB_LINK_CGS;
               end
            end
            slb_pkg::SLB_LINK_CGS: begin
               cgs_cnt_q <= cgs_cnt_q + 16'h0001;
               if (!phy_en_o) begin
                  link_q <= slb_pkg::SLB_LINK_IDLE;
               end else if (cgs_cnt_q >= 16'(slb_pkg::CGS_CYCLES - 1)) begin
                  link_q <= slb_pkg::SLB_LINK_UP;
               end
            end
            slb_pkg::SLB_LINK_UP: begin
               if (!phy_en_o) begin
                  link_q <= slb_pkg::SLB_LINK_IDLE;
               end
            end
            default: link_q <= slb_pkg::SLB_LINK_IDLE;
         endcase
      end
   end
   assign cgs_active_o = (link_q == slb_pkg::SLB_LINK_CGS);
   assign link_up_o = (link_q == slb_pkg::SLB_LINK_UP);

   // one-cycle alignment pulse
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         align_q <= 1'b0;
      end else begin
         align_q <= hit(slb_pkg::REG_FIFO_ALIGN) &&
            (reg_wdata_i == slb_pkg::ALIGN_CODE);
      end
   end
   assign fifo_align_o = align_q;

   // ********************************************************
   // fifo clock delay tuning
   // ********************************************************
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         dly1_q <= slb_pkg::DLY_RST;
         dly2_q <= slb_pkg::DLY_RST;
      end else begin
         if (hit(slb_pkg::REG_DLY_FIRST)) begin
            dly1_q <= reg_wdata_i;
         end
         if (hit(slb_pkg::REG_DLY_SECOND)) begin
            dly2_q <= reg_wdata_i;
         end
      end
   end
   // first register steers write clock, second the read clock
   assign fifo_wr_dly_o = dly1_q[slb_pkg::DLY_FIELD_LSB +: 3];
   assign fifo_rd_dly_o = dly2_q[slb_pkg::DLY_FIELD_LSB +: 3];

   // ********************************************************
   // read back
   // ********************************************************
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd_i;
         if (reg_rd_i) begin
            case (reg_addr_i)
               slb_pkg::REG_LOCK_STATUS: rdata_q <= pll_locked_i ?
                  slb_pkg::LOCK_CODE : slb_pkg::UNLOCK_CODE;
               slb_pkg::REG_SYSREF_CTRL: rdata_q <= sysref_live_q;
               slb_pkg::REG_PHY_CTRL: rdata_q <= phy_q;
               slb_pkg::REG_DLY_FIRST: rdata_q <= dly1_q;
               slb_pkg::REG_DLY_SECOND: rdata_q <= dly2_q;
               default: rdata_q <= 8'h00;
            endcase
         end
      end
   end
   assign reg_rdata_o = rdata_q;
   assign reg_rvalid_o = rvalid_q;

   // ********************************************************
   // checks
   // ********************************************************
   a_commit_apply: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      commit |=> sysref_live_q == $past(sysref_stage_q))
      else $error("commit did not apply staged value");
   a_stage_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !commit |=> $stable(sysref_live_q))
      else $error("live sysref changed without commit");
   a_capture_mode: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      sysref_capture_o |-> $past(sysref_i)
      && ($past(sysref_one_shot_o) || $past(sysref_periodic_o)))
      else $error("sysref captured outside a trigger mode");
   a_lock_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      reg_rd_i && reg_addr_i == slb_pkg::REG_LOCK_STATUS && pll_locked_i
      |=> reg_rvalid_o && reg_rdata_o == slb_pkg::LOCK_CODE)
      else $error("lock status not 0x81");
   a_phy_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      hit(slb_pkg::REG_PHY_CTRL) && reg_wdata_i == slb_pkg::PHY_ENABLE
      && link_q == slb_pkg::SLB_LINK_IDLE |=> ##1 cgs_active_o)
      else $error("cgs did not start");
   a_phy_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      hit(slb_pkg::REG_PHY_CTRL) && reg_wdata_i == slb_pkg::PHY_DISABLE
      |=> !phy_en_o ##1 !cgs_active_o && !link_up_o)
      else $error("phy not disabled");
   a_align_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      fifo_align_o |-> $past(reg_wr_i)
      && $past(reg_addr_i) == slb_pkg::REG_FIFO_ALIGN
      && $past(reg_wdata_i) == slb_pkg::ALIGN_CODE)
      else $error("alignment pulse without write");
   a_dly_track: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      hit(slb_pkg::REG_DLY_SECOND)
      |=> fifo_rd_dly_o == 3'($past(reg_wdata_i)))
      else $error("read delay not updated");
   c_link_up: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      cgs_active_o ##1 link_up_o);
   c_one_shot: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      sysref_one_shot_o && sysref_capture_o);
   c_align: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      fifo_align_o);
endmodule

//--- testbench.sv
// testbench.sv: self-checking bench of the bring-up sequencer
`timescale 1ns/10ps
module testbench;
   // ****************************************
   // harness
   // ****************************************
   localparam int LMFC_CYCLES = 8; // lmfc period, arbitrary
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic pll_locked_i = 1'b0;
   logic wr, rd, sref, rvalid, phy_en, cgs, up, align, buf_en, one, per, cap;
   logic [7:0] addr, wdata, rdata;
   logic [2:0] wr_dly, rd_dly;
   int n_mismatch = 0;
   int total_checks = 0;
   always #50 sys_clk_i = ~sys_clk_i;
   slb_sequencer u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .pll_locked_i(pll_locked_i), .sysref_i(sref), .phy_en_o(phy_en),
      .cgs_active_o(cgs), .link_up_o(up), .fifo_align_o(align),
      .sysref_buf_en_o(buf_en), .sysref_one_shot_o(one),
      .sysref_periodic_o(per), .sysref_capture_o(cap),
      .fifo_wr_dly_o(wr_dly), .fifo_rd_dly_o(rd_dly));
   slb_host_model u_host (.sys_clk_i(sys_clk_i), .reg_wr_o(wr),
      .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata),
      .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .sysref_o(sref));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      u_host.rd(a, d, v);
      chk(8'(v), 8'h01);
      chk(d, exp);
   endtask
   task automatic tick();
      @(posedge sys_clk_i);
      #1;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one-shot captures once, periodic on every high cycle
   function automatic logic [7:0] shots(input logic os, input int n);
      return os ? 8'h01 : 8'(n);
   endfunction
   task automatic burst(input int n, input logic os);
      int c;
      c = 0;
      fork
         u_host.pulse(n);
         begin
            repeat (n + 5) begin
               tick();
               c += int'(cap);
            end
         end
      join
      chk(8'(c), shots(os, n));
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      logic [7:0] v;
      int n;
      v = 8'($urandom(32'h122b));
      repeat (16) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      rd_chk(slb_pkg::REG_SYSREF_CTRL, slb_pkg::SYSREF_RST);
      rd_chk(slb_pkg::REG_PHY_CTRL, slb_pkg::PHY_RST);
      rd_chk(slb_pkg::REG_DLY_FIRST, slb_pkg::DLY_RST);
      rd_chk(8'h21, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk_i);
         pll_locked_i <= 1'($urandom);
         u_host.wr(slb_pkg::REG_LOCK_STATUS, 8'($urandom));
         rd_chk(slb_pkg::REG_LOCK_STATUS, pll_locked_i ?
            slb_pkg::LOCK_CODE : slb_pkg::UNLOCK_CODE);
      end
      @(posedge sys_clk_i);
      pll_locked_i <= 1'b1;
      u_host.wr(slb_pkg::REG_SYSREF_CTRL, slb_pkg::SYSREF_BUF_ONLY);
      tick();
      chk(8'(buf_en), 8'h00);
      u_host.commit();
      tick();
      chk(8'(buf_en), 8'h01);
      u_host.wr(slb_pkg::REG_SYSREF_CTRL, slb_pkg::SYSREF_ONE_SHOT);
      u_host.wr(slb_pkg::REG_COMMIT, 8'h02);
      tick();
      chk(8'(one), 8'h00);
      u_host.commit();
      tick();
      chk(8'({buf_en, one, per}), 8'h06);
      rd_chk(slb_pkg::REG_LOCK_STATUS, slb_pkg::LOCK_CODE);
      u_host.wr(slb_pkg::REG_PHY_CTRL, slb_pkg::PHY_ENABLE);
      tick();
      chk(8'(phy_en), 8'h01);
      tick();
      chk(8'(cgs), 8'h01);
      n = 0;
      while (up !== 1'b1 && n < 50) begin
         tick();
         n++;
      end
      if (n >= 50) begin
         n_mismatch++;
         close_out();
      end
      // cgs began one edge before the first poll
      chk(8'(n + 1), 8'(slb_pkg::CGS_CYCLES));
      u_host.wr(slb_pkg::REG_FIFO_ALIGN, 8'h12);
      tick();
      chk(8'(align), 8'h00);
      u_host.wr(slb_pkg::REG_FIFO_ALIGN, slb_pkg::ALIGN_CODE);
      // pulse stands only until the next edge
      #1;
      chk(8'(align), 8'h01);
      tick();
      chk(8'(align), 8'h00);
      repeat (6 * LMFC_CYCLES) @(posedge sys_clk_i);
      burst(3, 1'b1);
      u_host.wr(slb_pkg::REG_SYSREF_CTRL, slb_pkg::SYSREF_BUF_OFF);
      u_host.commit();
      tick();
      chk(8'({buf_en, one}), 8'h00);
      for (int i = 1; i <= 7; i++) begin
         u_host.wr(slb_pkg::REG_DLY_FIRST, 8'h80 | 8'(i));
         u_host.wr(slb_pkg::REG_DLY_SECOND, 8'h80 | 8'(i));
         tick();
         chk(8'({wr_dly, rd_dly}), 8'({3'(i), 3'(i)}));
      end
      repeat (6 * LMFC_CYCLES) @(posedge sys_clk_i);
      repeat (4) begin
         v = 8'($urandom);
         u_host.wr(slb_pkg::REG_DLY_SECOND, v);
         rd_chk(slb_pkg::REG_DLY_SECOND, v);
         chk(8'(rd_dly), 8'(v[2:0]));
      end
      u_host.wr(slb_pkg::REG_SYSREF_CTRL, slb_pkg::SYSREF_PERIODIC);
      u_host.commit();
      tick();
      chk(8'({one, per}), 8'h01);
      burst(4, 1'b0);
      u_host.wr(slb_pkg::REG_PHY_CTRL, slb_pkg::PHY_DISABLE);
      tick();
      tick();
      chk(8'({phy_en, cgs, up}), 8'h00);
      close_out();
   end
endmodule
